// ==== hdl/ccig_pkg.sv ====
/*
  Constants shared by the processor-core interrupt gating block: register byte
  offsets, field positions, reset values and the master clock divide ratio.
  Assumes an APB master with 32-bit data and word-aligned addresses.
*/
// Operation
// - A taken non-maskable request steers the core to the reset vector and no mask or enable bit can stop it.
// - The non-maskable line is captured on each rising edge of the core master clock and the captured value is inverted.
// - A non-maskable request has effect only while the pipeline runs and none while it is stalled or stopped.
// - Ordinary requests are masked by mask bits 6 to 2 together with the global gate and the exception level bit.
// - Pending bits 1 and 0 are software interrupts that software writes and no hardware event sets or clears.
// - Software requests are masked by mask bits 1 and 0 together with the global gate and the exception level bit.
// - Pending bit 7 is set whenever the count value becomes equal to the compare value; here a compare write that makes them equal clears it instead.
// - The timer request is masked by mask bit 7 together with the global gate and the exception level bit.
// - The timer pending bit reads back latched at cause bit 15.
// - Interrupt register bits 4 to 0 are ORed with the live request lines and read back as cause bits 14 to 10.
// - Each pending bit 15 to 8 is ANDed with the mask bit at its position and the eight products are ORed.
// - The global gate in status bit 0 is ANDed with that result to form the core interrupt request.
// - The exception level bit also gates the core interrupt request.
package ccig_pkg;

  // --------------------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_CAUSE    = 8'h04;
  localparam logic [7:0] OFF_COUNT    = 8'h08;
  localparam logic [7:0] OFF_COMPARE  = 8'h0c;
  localparam logic [7:0] OFF_INTREG   = 8'h10;
  localparam logic [7:0] OFF_EVT_STAT = 8'h14;
  localparam logic [7:0] OFF_EVT_MASK = 8'h18;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int GATE_BIT      = 0;
  localparam int EXL_BIT       = 1;
  localparam int FIELD_LSB     = 8;
  localparam int FIELD_MSB     = 15;
  localparam int SW_LSB        = 8;
  localparam int SW_MSB        = 9;
  localparam int EVT_TIMER_BIT = 0;
  localparam int EVT_NMI_BIT   = 1;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0]  RST_MASK    = 8'h00;
  localparam logic        RST_GATE    = 1'h0;
  localparam logic        RST_EXL     = 1'h1;
  localparam logic [4:0]  RST_INTREG  = 5'h00;
  localparam logic [31:0] RST_COUNT   = 32'h0000_0000;
  localparam logic [31:0] RST_COMPARE = 32'hffff_ffff;
  localparam logic [1:0]  RST_EVT     = 2'h0;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam logic [1:0]  MASTER_DIV_LAST = 2'h3;

endpackage

// ==== hdl/ccig_timer.sv ====
/*
  Count and compare pair of the core timer with its equality detector.
  Assumes a one-cycle tick enable from the core master clock divider and
  write strobes from the register slave on the same clock.
*/
`timescale 1ns/100ps
module ccig_timer
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        cnt_wr,
  input  wire logic        cmp_wr,
  input  wire logic [31:0] wdata,
  output logic      [31:0] count,
  output logic      [31:0] compare,
  output logic             match
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed
  {
    logic [31:0] count;
    logic [31:0] compare;
    logic        match;
  } ccig_tmr_t;

  ccig_tmr_t s_q;
  ccig_tmr_t s_d;

  always_comb
  begin
    s_d       = s_q;
    s_d.match = 1'b0;
    if (cnt_wr)
    begin
      s_d.count = wdata;
    end
    else if (tick)
    begin
      s_d.count = s_q.count + 32'h0000_0001;
    end
    if (cmp_wr)
    begin
      s_d.compare = wdata;
    end
    // Pulse only when the count arrives at the compare value, not while it rests there
    s_d.match = (s_d.count == s_d.compare) && (s_q.count != s_d.count);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q.count   <= ccig_pkg::RST_COUNT;
      s_q.compare <= ccig_pkg::RST_COMPARE;
      s_q.match   <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign count   = s_q.count;
  assign compare = s_q.compare;
  assign match   = s_q.match;

endmodule

// ==== hdl/ccig_top.sv ====
/*
  Processor-core interrupt gating: merges five ordinary request lines, two
  software pending bits and the timer into the cause pending field, gates them
  with status and drives the core request; the non-maskable line drives the reset vector request. APB slave.
  Assumes request lines and pipeline state come from logic on CLOCK; the
  non-maskable line is a pin and is synchronised.
*/
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/100ps
module ccig_top
(
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        NMI_N,
  input  wire logic [4:0]  INT_REQ,
  input  wire logic        PIPE_RUN,
  output logic             CORE_IRQ,
  output logic             RESET_VEC_REQ,
  output logic             IRQ
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic hit(input logic [31:0] addr, input logic [7:0] off);
    hit = (addr[31:8] == 24'h00_0000) && (addr[7:0] == off);
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed
  {
    logic [2:0]  sync;
    logic        nmi_lvl;
    logic        nmi_cap;
    logic        nmi_prev;
    logic [1:0]  div;
    logic        tick;
    logic [7:0]  mask;
    logic        gate;
    logic        exception_level_bit;
    logic [1:0]  sw_pend;
    logic        tmr_pend;
    logic [4:0]  int_reg;
    logic [1:0]  evt_stat;
    logic [1:0]  evt_mask;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        core_irq;
    logic        reset_vec;
    logic        irq;
  } ccig_state_t;

  ccig_state_t s_q;
  ccig_state_t s_d;

  logic [31:0] count;
  logic [31:0] compare;
  logic        match;
  logic        acc;
  logic        wr;
  logic        setup;
  logic [7:0]  pend;
  logic        nmi_req;

  assign acc   = PSEL && PENABLE && s_q.pready;
  assign wr    = acc && PWRITE;
  assign setup = PSEL && !PENABLE && !s_q.pready;

  // Line 4 is never raised by the source, but is merged the same way
  assign pend = {s_q.tmr_pend, s_q.int_reg | INT_REQ, s_q.sw_pend};

  // Captured level is low-active at the pin; inverting gives the request
  assign nmi_req = !s_q.nmi_cap;

  // --------------------------------------------------------------------------
  // Timer
  // --------------------------------------------------------------------------
  ccig_timer u_timer
  (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .tick    (s_q.tick),
    .cnt_wr  (wr && hit(PADDR, ccig_pkg::OFF_COUNT)),
    .cmp_wr  (wr && hit(PADDR, ccig_pkg::OFF_COMPARE)),
    .wdata   (PWDATA),
    .count   (count),
    .compare (compare),
    .match   (match)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;

    // Pin synchroniser; a change counts once the second and third flops agree
    s_d.sync = {s_q.sync[1:0], NMI_N};
    if (s_q.sync[1] == s_q.sync[2])
    begin
      s_d.nmi_lvl = s_q.sync[2];
    end

    // Core master clock as a one-cycle enable
    s_d.div  = (s_q.div == ccig_pkg::MASTER_DIV_LAST) ? 2'h0 : s_q.div + 2'h1;
    s_d.tick = (s_q.div == ccig_pkg::MASTER_DIV_LAST);
    if (s_q.tick)
    begin
      s_d.nmi_cap = s_q.nmi_lvl;
    end

    // Rising request steers to the reset vector only while the pipeline runs;
    // no mask, gate or exception level bit is consulted here
    s_d.nmi_prev  = nmi_req;
    s_d.reset_vec = nmi_req && !s_q.nmi_prev && PIPE_RUN;

    // Timer pending: a match in the same cycle as a compare write wins
    if (match)
    begin
      s_d.tmr_pend = 1'b1;
    end
    else if (wr && hit(PADDR, ccig_pkg::OFF_COMPARE))
    begin
      s_d.tmr_pend = 1'b0;
    end

    // Register writes
    if (wr && hit(PADDR, ccig_pkg::OFF_STATUS))
    begin
      s_d.mask = PWDATA[ccig_pkg::FIELD_MSB:ccig_pkg::FIELD_LSB];
      s_d.gate = PWDATA[ccig_pkg::GATE_BIT];
      s_d.exception_level_bit  = PWDATA[ccig_pkg::EXL_BIT];
    end
    // Only software touches these two bits
    if (wr && hit(PADDR, ccig_pkg::OFF_CAUSE))
    begin
      s_d.sw_pend = PWDATA[ccig_pkg::SW_MSB:ccig_pkg::SW_LSB];
    end
    if (wr && hit(PADDR, ccig_pkg::OFF_INTREG))
    begin
      s_d.int_reg = PWDATA[4:0];
    end
    if (wr && hit(PADDR, ccig_pkg::OFF_EVT_MASK))
    begin
      s_d.evt_mask = PWDATA[1:0];
    end

    // Sticky events: write one to clear, a new event in the same cycle wins
    if (wr && hit(PADDR, ccig_pkg::OFF_EVT_STAT))
    begin
      s_d.evt_stat = s_q.evt_stat & ~PWDATA[1:0];
    end
    if (match)
    begin
      s_d.evt_stat[ccig_pkg::EVT_TIMER_BIT] = 1'b1;
    end
    if (s_q.reset_vec)
    begin
      s_d.evt_stat[ccig_pkg::EVT_NMI_BIT] = 1'b1;
    end
    s_d.irq = |(s_d.evt_stat & s_d.evt_mask);

    // Per-source AND-OR, then global gate and exception level; a level, so it
    // holds as long as any unmasked source stays pending
    s_d.core_irq = s_q.gate && !s_q.exception_level_bit && |(pend & s_q.mask);

    // APB: read data captured in setup, ready in the first access cycle
    s_d.pready  = setup;
    s_d.pslverr = 1'b0;
    if (setup)
    begin
      s_d.prdata = 32'h0000_0000;
      if (hit(PADDR, ccig_pkg::OFF_STATUS))
      begin
        s_d.prdata[ccig_pkg::FIELD_MSB:ccig_pkg::FIELD_LSB] = s_q.mask;
        s_d.prdata[ccig_pkg::GATE_BIT]                      = s_q.gate;
        s_d.prdata[ccig_pkg::EXL_BIT]                       = s_q.exception_level_bit;
      end
      else if (hit(PADDR, ccig_pkg::OFF_CAUSE))
      begin
        s_d.prdata[ccig_pkg::FIELD_MSB:ccig_pkg::FIELD_LSB] = pend;
      end
      else if (hit(PADDR, ccig_pkg::OFF_COUNT))
      begin
        s_d.prdata = count;
      end
      else if (hit(PADDR, ccig_pkg::OFF_COMPARE))
      begin
        s_d.prdata = compare;
      end
      else if (hit(PADDR, ccig_pkg::OFF_INTREG))
      begin
        s_d.prdata[4:0] = s_q.int_reg;
      end
      else if (hit(PADDR, ccig_pkg::OFF_EVT_STAT))
      begin
        s_d.prdata[1:0] = s_q.evt_stat;
      end
      else if (hit(PADDR, ccig_pkg::OFF_EVT_MASK))
      begin
        s_d.prdata[1:0] = s_q.evt_mask;
      end
      else
      begin
        s_d.pslverr = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      s_q.sync      <= 3'h7;
      s_q.nmi_lvl   <= 1'b1;
      s_q.nmi_cap   <= 1'b1;
      s_q.nmi_prev  <= 1'b0;
      s_q.div       <= 2'h0;
      s_q.tick      <= 1'b0;
      s_q.mask      <= ccig_pkg::RST_MASK;
      s_q.gate      <= ccig_pkg::RST_GATE;
      s_q.exception_level_bit       <= ccig_pkg::RST_EXL;
      s_q.sw_pend   <= 2'h0;
      s_q.tmr_pend  <= 1'b0;
      s_q.int_reg   <= ccig_pkg::RST_INTREG;
      s_q.evt_stat  <= ccig_pkg::RST_EVT;
      s_q.evt_mask  <= ccig_pkg::RST_EVT;
      s_q.pready    <= 1'b0;
      s_q.prdata    <= 32'h0000_0000;
      s_q.pslverr   <= 1'b0;
      s_q.core_irq  <= 1'b0;
      s_q.reset_vec <= 1'b0;
      s_q.irq       <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign PRDATA        = s_q.prdata;
  assign PREADY        = s_q.pready;
  assign PSLVERR       = s_q.pslverr;
  assign CORE_IRQ      = s_q.core_irq;
  assign RESET_VEC_REQ = s_q.reset_vec;
  assign IRQ           = s_q.irq;

endmodule

// ==== verification/ccig_monitor.sv ====
/* Port checker for ccig_top.
   Bound to every ccig_top instance; sees its ports only. */
`timescale 1ns/100ps
module ccig_monitor
(
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        NMI_N,
  input wire logic [4:0]  INT_REQ,
  input wire logic        PIPE_RUN,
  input wire logic        CORE_IRQ,
  input wire logic        RESET_VEC_REQ,
  input wire logic        IRQ
);
  logic bad;
  assign bad = (PADDR[31:8] != 24'h0) || (PADDR[1:0] != 2'h0) || (PADDR[7:0] > ccig_pkg::OFF_EVT_MASK);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  chk_reset_quiet: assert property ($past(SYS_RST) |-> !CORE_IRQ && !IRQ && !RESET_VEC_REQ)
    else $error("output active after reset");
  chk_ready_next: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready late");
  chk_ready_phase: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  chk_err_decode: assert property (PREADY |-> PSLVERR == bad)
    else $error("slave error wrong");
  chk_err_rdzero: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_nmi_pulse: assert property (RESET_VEC_REQ |=> !RESET_VEC_REQ)
    else $error("vector request too long");
  chk_nmi_cause: assert property (RESET_VEC_REQ |-> !$past(NMI_N, 3))
    else $error("vector request without pin");
  chk_nmi_run: assert property (RESET_VEC_REQ |-> $past(PIPE_RUN))
    else $error("vector request while stalled");
  chk_nmi_taken: assert property ($fell(NMI_N) |-> ##[1:10] (RESET_VEC_REQ || !PIPE_RUN))
    else $error("nonmaskable request lost");
  chk_irq_hold: assert property (CORE_IRQ && !PSEL && !$past(PSEL) && $stable(INT_REQ)
    && $past(INT_REQ, 2) == INT_REQ |=> CORE_IRQ)
    else $error("core request dropped");
  cover property (RESET_VEC_REQ);
  cover property ($rose(CORE_IRQ));
  cover property (PREADY && PSLVERR);
  cover property ($rose(IRQ));
endmodule
bind ccig_top ccig_monitor u_mon
(
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .NMI_N(NMI_N), .INT_REQ(INT_REQ), .PIPE_RUN(PIPE_RUN), .CORE_IRQ(CORE_IRQ),
  .RESET_VEC_REQ(RESET_VEC_REQ), .IRQ(IRQ)
);

// ==== verification/ccig_icu_model.sv ====
/* Far-side model: request lines, nonmaskable pin and pipeline state.
   Driven by the bench on the same clock. */
`timescale 1ns/100ps
module ccig_icu_model
(
  input  wire logic       clk,
  input  wire logic [3:0] src,
  input  wire logic       nmi_go,
  input  wire logic       run,
  output logic      [4:0] int_req,
  output logic            nmi_n,
  output logic            pipe_run
);
  logic [3:0] hold_q;
  initial
  begin
    int_req = 5'h0;
    nmi_n = 1'h1;
    pipe_run = 1'h1;
    hold_q = 4'h0;
  end
  // Pin held low 10 cycles so the synchroniser cannot miss it
  always @(posedge clk)
  begin
    int_req <= {1'h0, src};
    pipe_run <= run;
    hold_q <= nmi_go ? 4'ha : (hold_q != 4'h0 ? hold_q - 4'h1 : 4'h0);
    nmi_n <= !(nmi_go || hold_q > 4'h1);
  end
endmodule

// ==== verification/tb_top.sv ====
/* Self-checking bench for ccig_top.
   Assumes the far-side model and the bound port checker. */
`timescale 1ns/100ps
module tb_top;
  logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, core_irq, rv_req, irq, nmi_n, pipe_run, e;
  logic        nmi_go = 1'h0, run = 1'h1;
  logic [4:0]  int_req;
  logic [3:0]  src = 4'h0;
  int          fail_count = 0, total_checks = 0;
  initial forever #5 clk = ~clk;
  ccig_top u_dut(.CLOCK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .NMI_N(nmi_n), .INT_REQ(int_req), .PIPE_RUN(pipe_run), .CORE_IRQ(core_irq),
    .RESET_VEC_REQ(rv_req), .IRQ(irq));
  ccig_icu_model u_icu(.clk(clk), .src(src), .nmi_go(nmi_go), .run(run), .int_req(int_req),
    .nmi_n(nmi_n), .pipe_run(pipe_run));
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // Ready and read data are taken as sampled at the completing rising edge
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (pready === 1'h1)
        break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n == 20)
    begin
      fail_count++;
      test_done();
    end
  endtask
  // Core request settles one cycle after the state it follows
  task automatic irq_is(input logic x);
    repeat (3) @(negedge clk);
    chk("core_irq", {31'h0, x}, {31'h0, core_irq});
  endtask
  task automatic nmi_count(input logic [31:0] x);
    int n, k;
    nmi_go <= 1'h1;
    @(posedge clk);
    nmi_go <= 1'h0;
    k = 0;
    for (n = 0; n < 20; n++)
    begin
      @(negedge clk);
      if (rv_req === 1'h1)
        k++;
    end
    chk("vector_pulses", x, k);
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_soft;
    apb(1'h0, ccig_pkg::OFF_STATUS, 32'h0);
    chk("status", 32'h2, r & 32'hff03);
    apb(1'h1, ccig_pkg::OFF_STATUS, 32'h0103);
    apb(1'h1, ccig_pkg::OFF_CAUSE, 32'h100);
    irq_is(1'h0);
    apb(1'h1, ccig_pkg::OFF_STATUS, 32'h0101);
    irq_is(1'h1);
    apb(1'h0, ccig_pkg::OFF_CAUSE, 32'h0);
    chk("cause", 32'h100, r & 32'hff00);
    apb(1'h1, ccig_pkg::OFF_STATUS, 32'h0100);
    irq_is(1'h0);
    apb(1'h1, ccig_pkg::OFF_STATUS, 32'h0201);
    irq_is(1'h0);
    apb(1'h1, ccig_pkg::OFF_CAUSE, 32'h0);
  endtask
  task automatic t_lines;
    int i;
    for (i = 0; i < 4; i++)
    begin
      src <= 4'h1 << i;
      apb(1'h1, ccig_pkg::OFF_STATUS, (32'h400 << i) | 32'h1);
      irq_is(1'h1);
      apb(1'h0, ccig_pkg::OFF_CAUSE, 32'h0);
      chk("cause", 32'h400 << i, r & 32'hff00);
      apb(1'h1, ccig_pkg::OFF_STATUS, (32'h400 << ((i + 1) % 4)) | 32'h1);
      irq_is(1'h0);
    end
    src <= 4'h0;
    apb(1'h1, ccig_pkg::OFF_INTREG, 32'h10);
    apb(1'h1, ccig_pkg::OFF_STATUS, 32'h4001);
    irq_is(1'h1);
    apb(1'h1, ccig_pkg::OFF_INTREG, 32'h0);
    irq_is(1'h0);
  endtask
  task automatic t_timer;
    int n;
    apb(1'h1, ccig_pkg::OFF_STATUS, 32'h1);
    apb(1'h1, ccig_pkg::OFF_EVT_MASK, 32'h1);
    apb(1'h1, ccig_pkg::OFF_COUNT, 32'h0);
    apb(1'h1, ccig_pkg::OFF_COMPARE, 32'h20);
    for (n = 0; n < 300 && irq !== 1'h1; n++)
      @(negedge clk);
    if (n == 300)
    begin
      fail_count++;
      test_done();
    end
    irq_is(1'h0);
    apb(1'h0, ccig_pkg::OFF_CAUSE, 32'h0);
    chk("cause", 32'h8000, r & 32'hff00);
    apb(1'h1, ccig_pkg::OFF_STATUS, 32'h8001);
    irq_is(1'h1);
    apb(1'h1, ccig_pkg::OFF_EVT_STAT, 32'h1);
    // The clear lands at the completing edge; look once the output has moved
    @(negedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'h1, ccig_pkg::OFF_COMPARE, 32'hffffffff);
    irq_is(1'h0);
    apb(1'h0, ccig_pkg::OFF_CAUSE, 32'h0);
    chk("cause", 32'h0, r & 32'hff00);
  endtask
  task automatic t_nmi;
    apb(1'h1, ccig_pkg::OFF_STATUS, 32'h2);
    apb(1'h1, ccig_pkg::OFF_EVT_STAT, 32'h3);
    nmi_count(32'h1);
    apb(1'h0, ccig_pkg::OFF_EVT_STAT, 32'h0);
    chk("evt_stat", 32'h2, r & 32'h3);
    run <= 1'h0;
    nmi_count(32'h0);
    run <= 1'h1;
    apb(1'h0, 8'h20, 32'h0);
    chk("rd_err", 32'h1, {31'h0, e});
    chk("rd_data", 32'h0, r);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    t_soft();
    t_lines();
    t_timer();
    t_nmi();
    test_done();
  end
endmodule
